// >>> core/flow_cfg_pkg.sv
// Shared constants and state types for the channel configuration block
package flow_cfg_pkg;
	localparam int AW = 5;
	// Register indices on the plain register port
	localparam logic [4:0] A_IER   = 5'h00;
	localparam logic [4:0] A_ISR   = 5'h01;
	localparam logic [4:0] A_FCR   = 5'h02;
	localparam logic [4:0] A_LCR   = 5'h03;
	localparam logic [4:0] A_MCR   = 5'h04;
	localparam logic [4:0] A_LSR   = 5'h05;
	localparam logic [4:0] A_MSR   = 5'h06;
	localparam logic [4:0] A_SPR   = 5'h07;
	localparam logic [4:0] A_DLL   = 5'h08;
	localparam logic [4:0] A_DLM   = 5'h09;
	localparam logic [4:0] A_DLD   = 5'h0A;
	localparam logic [4:0] A_FCTL  = 5'h0B;
	localparam logic [4:0] A_EFEAT = 5'h0C;
	localparam logic [4:0] A_TRG   = 5'h0D;
	localparam logic [4:0] A_RES1  = 5'h0E;
	localparam logic [4:0] A_RES2  = 5'h0F;
	localparam logic [4:0] A_PAU1  = 5'h10;
	localparam logic [4:0] A_PAU2  = 5'h11;
	// Reset values
	localparam logic [7:0] ISR_RST  = 8'h01;
	localparam logic [7:0] LSR_RST  = 8'h60;
	localparam logic [7:0] SPR_RST  = 8'hFF;
	localparam logic [7:0] ENHANCED_MODE_SELECT_RST = 8'h80;
	localparam logic [7:0] DLL_POR  = 8'h01;
	localparam logic [7:0] DLM_POR  = 8'h00;
	// Field positions
	localparam int FCTL_TXSEL = 7;
	localparam int FCTL_SWAP  = 6;
	localparam int EF_ENH     = 4;
	localparam logic [7:0] IER_ENH = 8'hF0;
	localparam logic [7:0] ISR_ENH = 8'h30;
	localparam logic [7:0] FCR_ENH = 8'h30;
	localparam logic [7:0] MCR_ENH = 8'hE0;
	localparam logic [1:0] FC_OFF  = 2'b00;
	localparam logic [1:0] FC_ONE  = 2'b10;
	localparam logic [1:0] FC_TWO  = 2'b01;
	localparam logic [1:0] FC_BOTH = 2'b11;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_ONE  = 3'b010,
		TX_TWO  = 3'b100
	} tx_state_e;

	typedef struct packed {
		logic [7:0] irq_enable_reg;
		logic [7:0] irq_status_reg;
		logic [7:0] fifo_control;
		logic [7:0] line_control;
		logic [7:0] modem_control;
		logic [7:0] line_status;
		logic [3:0] msr_lo;
		logic [3:0] modem_prev;
		logic [7:0] scratch_byte;
		logic [7:0] enhanced_mode_select;
		logic       alt_tx;
		logic [7:0] divisor_fraction;
		logic [7:0] fctl;
		logic [7:0] efeat;
		logic [7:0] trg_rx;
		logic [7:0] trg_tx;
		logic [7:0] res1;
		logic [7:0] res2;
		logic [7:0] pau1;
		logic [7:0] pau2;
		logic [7:0] rdata;
		logic       seen_res1;
		logic       seen_pau1;
		logic       rx_pause;
		logic       rx_resume;
		tx_state_e  tx_st;
		logic       tx_kind;
		logic [7:0] tx_char;
		logic       tx_vld;
		logic       irq;
		logic       irq_oe16_n;
		logic       irq_oe68_n;
		logic [1:0] tx485;
		logic [1:0] rx485;
		logic       aux_tx;
	} state_s;

	typedef struct packed {
		logic [7:0] dll;
		logic [7:0] divisor_high;
	} div_s;
endpackage

// >>> core/flow_cfg.sv
// One UART channel: flow control, enhanced write gate and reset behaviour
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/100ps
module flow_cfg
	import flow_cfg_pkg::*;
(
	input  wire logic          CLK_I,        // Channel clock, 20 MHz
	input  wire logic          RSTN_I,       // Reset pin, async, active low
	input  wire logic          PORN_I,       // Power-up reset, async, active low
	input  wire logic          CE_I,         // Clock enable, freezes all state
	input  wire logic [AW-1:0] ADDR_I,       // Register index
	input  wire logic [7:0]    WDATA_I,      // Write data
	input  wire logic          WR_I,         // Write strobe
	input  wire logic          RD_I,         // Read strobe
	output logic [7:0]         RDATA_O,      // Read data, cycle after strobe
	input  wire logic [7:0]    ISR_I,        // Interrupt status from core
	input  wire logic [7:0]    LSR_I,        // Line status from core
	input  wire logic [3:0]    MODEM_I,      // Modem inputs, pin levels
	input  wire logic [7:0]    RX_CNT_I,     // Receive FIFO fill
	input  wire logic [7:0]    TX_CNT_I,     // Transmit FIFO fill
	input  wire logic [7:0]    RX_CHAR_I,    // Received character
	input  wire logic          RX_VLD_I,     // Received character valid
	output logic               RX_PAUSE_O,   // Pause seen, pulse
	output logic               RX_RESUME_O,  // Resume seen, pulse
	input  wire logic          TX_REQ_I,     // Request a flow character send
	input  wire logic          TX_KIND_I,    // 1 pause, 0 resume
	input  wire logic          TX_TAKEN_I,   // Transmitter took the character
	output logic [7:0]         TX_CHAR_O,    // Flow character to send
	output logic               TX_VLD_O,     // Flow character valid
	output logic [7:0]         TRG_RX_O,     // Receive trigger level
	output logic [7:0]         TRG_TX_O,     // Transmit trigger level
	output logic [15:0]        DIV_O,        // Integer divisor
	output logic [7:0]         DIV_FRAC_O,   // Fraction divisor
	input  wire logic          BUS68_I,      // Bus mode strap, 1 = 68 style
	input  wire logic          IRQ_REQ_I,    // Interrupt request, active high
	output logic               IRQ_O,        // Interrupt pin level
	output logic               IRQ_OE16_N_O, // Pin enable in 16 mode, low drives
	output logic               IRQ_OE68_N_O, // Pin enable in 68 mode, low drives
	input  wire logic [1:0]    TX_LINE_I,    // Serial out of both channels
	input  wire logic [1:0]    RX_LINE_I,    // Receiver enables of both channels
	output logic [1:0]         TX485_O,      // Line driver inputs
	output logic [1:0]         RX485_O,      // Line receiver controls
	output logic               AUX_TX_O      // Aux CMOS transmit output
);

	state_s st_r;
	state_s st_nxt;
	div_s   div_r;
	div_s   div_nxt;

	// Either of two characters, each enabled by one select bit
	function automatic logic hit(input logic [7:0] c, input logic [7:0] one,
		input logic [7:0] two, input logic [1:0] sel);
		hit = (sel[1] && (c == one)) || (sel[0] && (c == two));
	endfunction

	// Write under the enhance gate: gated bits keep old value when locked
	function automatic logic [7:0] gate(input logic [7:0] old, input logic [7:0] wd,
		input logic [7:0] msk, input logic en);
		gate = en ? wd : ((old & msk) | (wd & ~msk));
	endfunction

	logic [1:0] tx_mode;
	logic [1:0] rx_mode;
	logic       enh;
	logic       wr;
	logic       rd;
	logic [7:0] cnt_sel;
	logic [7:0] lvl_view;

	assign tx_mode = st_r.efeat[3:2];
	assign rx_mode = st_r.efeat[1:0];
	assign enh     = st_r.efeat[EF_ENH];
	assign wr      = CE_I && WR_I;
	assign rd      = CE_I && RD_I;
	assign cnt_sel = st_r.fctl[FCTL_TXSEL] ? TX_CNT_I : RX_CNT_I;

	always_comb
	begin
		if (st_r.enhanced_mode_select[0] == 1'b0)
		begin
			lvl_view = RX_CNT_I;
		end
		else if (st_r.enhanced_mode_select[1] == 1'b0)
		begin
			lvl_view = TX_CNT_I;
		end
		else
		begin
			lvl_view = st_r.alt_tx ? TX_CNT_I : RX_CNT_I;
		end
	end

	always_comb
	begin
		st_nxt  = st_r;
		div_nxt = div_r;
		if (CE_I)
		begin
			// Status shadows; enhanced status bits stay under software control
			st_nxt.irq_status_reg = (ISR_I & ~ISR_ENH) | (st_r.irq_status_reg & ISR_ENH);
			st_nxt.line_status = LSR_I;
			st_nxt.modem_prev = MODEM_I;
			// Delta bits: a change in the read cycle still sets them
			if (rd && (ADDR_I == A_MSR))
			begin
				st_nxt.msr_lo = 4'h0;
			end
			st_nxt.msr_lo = st_nxt.msr_lo | (MODEM_I ^ st_r.modem_prev);
			st_nxt.rdata = 8'h00;
			st_nxt.rx_pause = 1'b0;
			st_nxt.rx_resume = 1'b0;

			if (wr)
			begin
				if (ADDR_I == A_IER)
					st_nxt.irq_enable_reg = gate(st_r.irq_enable_reg, WDATA_I, IER_ENH, enh);
				else if (ADDR_I == A_ISR)
				begin
					if (enh)
					begin
						st_nxt.irq_status_reg = (st_nxt.irq_status_reg & ~ISR_ENH) | (WDATA_I & ISR_ENH);
					end
				end
				else if (ADDR_I == A_FCR)
					st_nxt.fifo_control = gate(st_r.fifo_control, WDATA_I, FCR_ENH, enh);
				else if (ADDR_I == A_LCR)
					st_nxt.line_control = WDATA_I;
				else if (ADDR_I == A_MCR)
					st_nxt.modem_control = gate(st_r.modem_control, WDATA_I, MCR_ENH, enh);
				else if (ADDR_I == A_SPR)
				begin
					if (st_r.fctl[FCTL_SWAP])
					begin
						st_nxt.enhanced_mode_select = WDATA_I;
						st_nxt.alt_tx = 1'b0;
					end
					else
					begin
						st_nxt.scratch_byte = WDATA_I;
					end
				end
				else if (ADDR_I == A_DLL)
					div_nxt.dll = WDATA_I;
				else if (ADDR_I == A_DLM)
					div_nxt.divisor_high = WDATA_I;
				else if (ADDR_I == A_DLD)
				begin
					if (enh)
					begin
						st_nxt.divisor_fraction = WDATA_I;
					end
				end
				else if (ADDR_I == A_FCTL)
					st_nxt.fctl = WDATA_I;
				else if (ADDR_I == A_EFEAT)
				begin
					// Sequence flags restart; a char arriving in this cycle under an old sequence mode still sets them
					st_nxt.efeat = WDATA_I;
					st_nxt.seen_res1 = 1'b0;
					st_nxt.seen_pau1 = 1'b0;
				end
				else if (ADDR_I == A_TRG)
				begin
					if (st_r.fctl[FCTL_TXSEL])
					begin
						st_nxt.trg_tx = WDATA_I;
					end
					else
					begin
						st_nxt.trg_rx = WDATA_I;
					end
				end
				else if (ADDR_I == A_RES1)
					st_nxt.res1 = WDATA_I;
				else if (ADDR_I == A_RES2)
					st_nxt.res2 = WDATA_I;
				else if (ADDR_I == A_PAU1)
					st_nxt.pau1 = WDATA_I;
				else if (ADDR_I == A_PAU2)
					st_nxt.pau2 = WDATA_I;
			end

			if (rd)
			begin
				if (ADDR_I == A_IER)
					st_nxt.rdata = st_r.irq_enable_reg;
				else if (ADDR_I == A_ISR)
					st_nxt.rdata = st_r.irq_status_reg;
				else if (ADDR_I == A_LCR)
					st_nxt.rdata = st_r.line_control;
				else if (ADDR_I == A_MCR)
					st_nxt.rdata = st_r.modem_control;
				else if (ADDR_I == A_LSR)
					st_nxt.rdata = st_r.line_status;
				else if (ADDR_I == A_MSR)
					st_nxt.rdata = {~MODEM_I, st_r.msr_lo};
				else if (ADDR_I == A_SPR)
				begin
					if (st_r.fctl[FCTL_SWAP])
					begin
						st_nxt.rdata = lvl_view;
						st_nxt.alt_tx = ~st_r.alt_tx;
					end
					else
					begin
						st_nxt.rdata = st_r.scratch_byte;
					end
				end
				else if (ADDR_I == A_DLL)
					st_nxt.rdata = div_r.dll;
				else if (ADDR_I == A_DLM)
					st_nxt.rdata = div_r.divisor_high;
				else if (ADDR_I == A_DLD)
					st_nxt.rdata = st_r.divisor_fraction;
				else if (ADDR_I == A_FCTL)
					st_nxt.rdata = st_r.fctl;
				else if (ADDR_I == A_EFEAT)
					st_nxt.rdata = st_r.efeat;
				else if (ADDR_I == A_TRG)
					st_nxt.rdata = cnt_sel;
				else if (ADDR_I == A_RES1)
					st_nxt.rdata = st_r.res1;
				else if (ADDR_I == A_RES2)
					st_nxt.rdata = st_r.res2;
				else if (ADDR_I == A_PAU1)
					st_nxt.rdata = st_r.pau1;
				else if (ADDR_I == A_PAU2)
					st_nxt.rdata = st_r.pau2;
			end

			// Receive comparison; mode 00 compares nothing
			if (RX_VLD_I && (rx_mode != FC_OFF))
			begin
				if ((rx_mode != FC_BOTH) || (tx_mode == FC_ONE) || (tx_mode == FC_TWO))
				begin
					// Single pair, or either pair when receive bits are 11 and transmit bits are 10 or 01
					st_nxt.rx_pause = hit(RX_CHAR_I, st_r.pau1, st_r.pau2, rx_mode);
					st_nxt.rx_resume = hit(RX_CHAR_I, st_r.res1, st_r.res2, rx_mode);
				end
				else
				begin
					// Two-character sequence: first then second, nothing between
					st_nxt.rx_pause = st_r.seen_pau1 && (RX_CHAR_I == st_r.pau2);
					st_nxt.rx_resume = st_r.seen_res1 && (RX_CHAR_I == st_r.res2);
					st_nxt.seen_pau1 = (RX_CHAR_I == st_r.pau1);
					st_nxt.seen_res1 = (RX_CHAR_I == st_r.res1);
				end
			end

			// Transmit sequencer; select bits are read live, software must
			// zero them before changing mode
			case (st_r.tx_st)
				TX_IDLE:
				begin
					if (TX_REQ_I && (tx_mode != FC_OFF))
					begin
						st_nxt.tx_kind = TX_KIND_I;
						st_nxt.tx_vld = 1'b1;
						if (tx_mode[1])
						begin
							st_nxt.tx_st = TX_ONE;
							st_nxt.tx_char = TX_KIND_I ? st_r.pau1 : st_r.res1;
						end
						else
						begin
							st_nxt.tx_st = TX_TWO;
							st_nxt.tx_char = TX_KIND_I ? st_r.pau2 : st_r.res2;
						end
					end
				end
				TX_ONE:
				begin
					if (TX_TAKEN_I)
					begin
						if (tx_mode == FC_BOTH)
						begin
							st_nxt.tx_st = TX_TWO;
							st_nxt.tx_char = st_r.tx_kind ? st_r.pau2 : st_r.res2;
						end
						else
						begin
							st_nxt.tx_st = TX_IDLE;
							st_nxt.tx_vld = 1'b0;
						end
					end
				end
				TX_TWO:
				begin
					if (TX_TAKEN_I)
					begin
						st_nxt.tx_st = TX_IDLE;
						st_nxt.tx_vld = 1'b0;
					end
				end
				default:
				begin
					st_nxt.tx_st = TX_IDLE;
					st_nxt.tx_vld = 1'b0;
				end
			endcase

			// Pins after reset: both bus modes drive the interrupt line
			st_nxt.irq = BUS68_I ? ~IRQ_REQ_I : IRQ_REQ_I;
			st_nxt.irq_oe16_n = 1'b0;
			st_nxt.irq_oe68_n = 1'b0;
			st_nxt.tx485 = TX_LINE_I;
			st_nxt.rx485 = RX_LINE_I;
			st_nxt.aux_tx = TX_LINE_I[1];
		end
	end

	// Reset pin: everything except the integer divisor
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			st_r <= '0;
			st_r.tx_st <= TX_IDLE;
			st_r.irq_status_reg <= ISR_RST;
			st_r.line_status <= LSR_RST;
			st_r.scratch_byte <= SPR_RST;
			st_r.enhanced_mode_select <= ENHANCED_MODE_SELECT_RST;
			st_r.irq <= 1'b1;
			st_r.irq_oe16_n <= 1'b1;
			st_r.irq_oe68_n <= 1'b0;
			st_r.aux_tx <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Integer divisor survives the reset pin
	always_ff @(posedge CLK_I or negedge PORN_I)
	begin
		if (!PORN_I)
		begin
			div_r.dll <= DLL_POR;
			div_r.divisor_high <= DLM_POR;
		end
		else
		begin
			div_r <= div_nxt;
		end
	end

	assign RDATA_O      = st_r.rdata;
	assign RX_PAUSE_O   = st_r.rx_pause;
	assign RX_RESUME_O  = st_r.rx_resume;
	assign TX_CHAR_O    = st_r.tx_char;
	assign TX_VLD_O     = st_r.tx_vld;
	assign TRG_RX_O     = st_r.trg_rx;
	assign TRG_TX_O     = st_r.trg_tx;
	assign DIV_O        = {div_r.divisor_high, div_r.dll};
	assign DIV_FRAC_O   = st_r.divisor_fraction;
	assign IRQ_O        = st_r.irq;
	assign IRQ_OE16_N_O = st_r.irq_oe16_n;
	assign IRQ_OE68_N_O = st_r.irq_oe68_n;
	assign TX485_O      = st_r.tx485;
	assign RX485_O      = st_r.rx485;
	assign AUX_TX_O     = st_r.aux_tx;

endmodule

// >>> sim/flow_cfg_properties.sv
// Port assertions for the channel configuration block
`timescale 1ns/100ps
module flow_cfg_properties
	import flow_cfg_pkg::*;
(
	input wire logic          CLK_I,        // Clock
	input wire logic          RSTN_I,       // Reset pin
	input wire logic          PORN_I,       // Power-up reset
	input wire logic [AW-1:0] ADDR_I,       // Index
	input wire logic          WR_I,         // Write
	input wire logic          RD_I,         // Read
	input wire logic [7:0]    RDATA_O,      // Read data
	input wire logic          RX_VLD_I,     // Rx valid
	input wire logic          RX_PAUSE_O,   // Pause seen
	input wire logic          RX_RESUME_O,  // Resume seen
	input wire logic          TX_REQ_I,     // Tx request
	input wire logic          TX_TAKEN_I,   // Tx taken
	input wire logic [7:0]    TX_CHAR_O,    // Tx char
	input wire logic          TX_VLD_O,     // Tx valid
	input wire logic [7:0]    TRG_RX_O,     // Rx trigger
	input wire logic [15:0]   DIV_O,        // Divisor
	input wire logic [7:0]    DIV_FRAC_O,   // Fraction
	input wire logic          IRQ_OE16_N_O, // Enable 16
	input wire logic          IRQ_OE68_N_O, // Enable 68
	input wire logic          AUX_TX_O      // Aux out
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	property p_rst_pins;
		disable iff (1'b0) !RSTN_I |-> IRQ_OE16_N_O && !IRQ_OE68_N_O && AUX_TX_O;
	endproperty
	a_rst_pins: assert property (p_rst_pins)
		else $error("pins wrong in reset");
	property p_div_keep;
		disable iff (!PORN_I) !RSTN_I && !$past(RSTN_I) |-> $stable(DIV_O);
	endproperty
	a_div_keep: assert property (p_div_keep)
		else $error("divisor lost on reset pin");
	property p_rx_cause;
		RX_PAUSE_O || RX_RESUME_O |-> $past(RX_VLD_I);
	endproperty
	a_rx_cause: assert property (p_rx_cause)
		else $error("flow pulse without char");
	property p_tx_start;
		$rose(TX_VLD_O) |-> $past(TX_REQ_I);
	endproperty
	a_tx_start: assert property (p_tx_start)
		else $error("flow char without request");
	property p_tx_hold;
		TX_VLD_O && !TX_TAKEN_I |=> TX_VLD_O && $stable(TX_CHAR_O);
	endproperty
	a_tx_hold: assert property (p_tx_hold)
		else $error("flow char dropped");
	property p_rd_data;
		RDATA_O != 8'h00 |-> $past(RD_I);
	endproperty
	a_rd_data: assert property (p_rd_data)
		else $error("read data without read");
	property p_trg_chg;
		!$stable(TRG_RX_O) |-> $past(WR_I && ADDR_I == A_TRG);
	endproperty
	a_trg_chg: assert property (p_trg_chg)
		else $error("trigger changed unasked");
	property p_frac_chg;
		!$stable(DIV_FRAC_O) |-> $past(WR_I && ADDR_I == A_DLD);
	endproperty
	a_frac_chg: assert property (p_frac_chg)
		else $error("fraction changed unasked");
endmodule

// >>> sim/remote_station.sv
// Remote serial station: takes flow characters, sends characters in
`timescale 1ns/100ps
module remote_station (
	input  wire logic       clk_i,     // Clock
	input  wire logic       vld_i,     // Char offered
	input  wire logic [7:0] char_i,    // Char offered
	input  wire logic [3:0] stall_i,   // Wait before take
	output logic            taken_o,   // Char consumed
	output logic [7:0]      rx_char_o, // Char toward block
	output logic            rx_vld_o   // Char valid
);
	logic [3:0] cnt = 4'h0;
	logic [7:0] got [$];
	initial
	begin
		taken_o = 1'h0;
		rx_vld_o = 1'h0;
		rx_char_o = 8'h00;
	end
	always @(posedge clk_i)
		if (vld_i === 1'h1 && !taken_o && cnt >= stall_i)
		begin
			taken_o <= 1'h1;
			cnt     <= 4'h0;
			got.push_back(char_i);
		end
		else
		begin
			taken_o <= 1'h0;
			cnt     <= (vld_i === 1'h1) ? cnt + 4'h1 : 4'h0;
		end
	task automatic send(input logic [7:0] c);
		@(posedge clk_i);
		rx_char_o <= c;
		rx_vld_o  <= 1'h1;
		@(posedge clk_i);
		rx_vld_o  <= 1'h0;
		rx_char_o <= ~c; // No stale char once released
	endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench for the channel configuration block
`timescale 1ns/100ps
module tb;
	import flow_cfg_pkg::*;
	logic          CLK_I = 1'h0, RSTN_I = 1'h1, PORN_I = 1'h1, WR_I = 1'h0, RD_I = 1'h0;
	logic          TX_REQ_I = 1'h0, TX_KIND_I = 1'h0, IRQ_REQ_I = 1'h0, RX_VLD_I, TX_TAKEN_I;
	logic [AW-1:0] ADDR_I = 5'h00;
	logic [7:0]    WDATA_I = 8'h00, RX_CNT_I = 8'h00, TX_CNT_I = 8'h00, RX_CHAR_I, c1, c2;
	logic [1:0]    TX_LINE_I = 2'h1, RX_LINE_I = 2'h3, TX485_O, RX485_O;
	logic [3:0]    stall = 4'h0;
	logic [7:0]    RDATA_O, TX_CHAR_O, TRG_RX_O, TRG_TX_O, DIV_FRAC_O;
	logic [15:0]   DIV_O;
	logic          RX_PAUSE_O, RX_RESUME_O, TX_VLD_O, IRQ_O, IRQ_OE16_N_O, IRQ_OE68_N_O, AUX_TX_O;
	int            failures = 0, comparisons = 0, npau = 0, nres = 0, p0, r0;
	logic [12:0]   rtab [16] = '{{A_IER, 8'h00}, {A_ISR, 8'h01}, {A_FCR, 8'h00}, {A_LCR, 8'h00},
		{A_MCR, 8'h00}, {A_LSR, 8'h60}, {A_MSR, 8'hF0}, {A_SPR, 8'hFF}, {A_DLD, 8'h00},
		{A_FCTL, 8'h00}, {A_EFEAT, 8'h00}, {A_RES1, 8'h00}, {A_RES2, 8'h00},
		{A_PAU1, 8'h00}, {A_PAU2, 8'h00}, {5'h1F, 8'h00}};
	logic [25:0]   rxt [8] = '{{8'h10, 8'h13, 8'h14, 2'h0}, {8'h12, 8'h13, 8'h12, 2'h2},
		{8'h11, 8'h14, 8'h11, 2'h2}, {8'h1B, 8'h14, 8'h11, 2'h3}, {8'h17, 8'h12, 8'h13, 2'h3},
		{8'h1F, 8'h14, 8'h13, 2'h0}, {8'h1F, 8'h13, 8'h14, 2'h2}, {8'h13, 8'h11, 8'h12, 2'h1}};

	flow_cfg DUT (.CLK_I, .RSTN_I, .PORN_I, .CE_I(1'h1), .ADDR_I, .WDATA_I, .WR_I, .RD_I,
		.RDATA_O, .ISR_I(8'h01), .LSR_I(8'h60), .MODEM_I(4'h0), .RX_CNT_I, .TX_CNT_I,
		.RX_CHAR_I, .RX_VLD_I, .RX_PAUSE_O, .RX_RESUME_O, .TX_REQ_I, .TX_KIND_I, .TX_TAKEN_I,
		.TX_CHAR_O, .TX_VLD_O, .TRG_RX_O, .TRG_TX_O, .DIV_O, .DIV_FRAC_O, .BUS68_I(1'h1),
		.IRQ_REQ_I, .IRQ_O, .IRQ_OE16_N_O, .IRQ_OE68_N_O, .TX_LINE_I, .RX_LINE_I, .TX485_O,
		.RX485_O, .AUX_TX_O);
	remote_station u_rem (.clk_i(CLK_I), .vld_i(TX_VLD_O), .char_i(TX_CHAR_O), .stall_i(stall),
		.taken_o(TX_TAKEN_I), .rx_char_o(RX_CHAR_I), .rx_vld_o(RX_VLD_I));

	always #25 CLK_I = ~CLK_I;
	always @(posedge CLK_I)
	begin
		if (RX_PAUSE_O === 1'h1)
			npau <= npau + 1;
		if (RX_RESUME_O === 1'h1)
			nres <= nres + 1;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge CLK_I);
		ADDR_I  <= a;
		WDATA_I <= d;
		WR_I    <= 1'h1;
		@(posedge CLK_I);
		WR_I    <= 1'h0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge CLK_I);
		ADDR_I <= a;
		RD_I   <= 1'h1;
		@(posedge CLK_I);
		RD_I   <= 1'h0;
		@(negedge CLK_I);
		chk({8'h00, RDATA_O}, {8'h00, e});
	endtask
	task automatic end_reset;
		@(negedge CLK_I);
		chk({8'h00, IRQ_O, IRQ_OE16_N_O, IRQ_OE68_N_O, AUX_TX_O, TX485_O, RX485_O}, 16'h00D0);
		@(posedge CLK_I);
		RSTN_I <= 1'h1;
	endtask
	task automatic report_and_stop;
		$display("Comparisons %0d, failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		RSTN_I <= 1'h0;
		PORN_I <= 1'h0;
		repeat (5) @(posedge CLK_I);
		PORN_I <= 1'h1;
		repeat (3) @(posedge CLK_I);
		wr(A_SPR, 8'h00);
		end_reset();
		chk(DIV_O, 16'h0001);
		foreach (rtab[i])
			rd(rtab[i][12:8], rtab[i][7:0]);
		wr(A_IER, 8'hFF);
		rd(A_IER, 8'h0F);
		wr(A_EFEAT, 8'h10);
		wr(A_IER, 8'hA3);
		wr(A_MCR, 8'hE1);
		wr(A_DLD, 8'h5A);
		wr(A_EFEAT, 8'h00);
		wr(A_IER, 8'h0C);
		wr(A_MCR, 8'h02);
		wr(A_DLD, 8'hA5);
		rd(A_IER, 8'hAC);
		rd(A_MCR, 8'hE2);
		rd(A_DLD, 8'h5A);
		wr(A_DLL, 8'h34);
		wr(A_DLM, 8'h12);
		@(posedge CLK_I);
		RSTN_I <= 1'h0;
		wr(A_SPR, 8'h00);
		end_reset();
		chk(DIV_O, 16'h1234);
		chk({8'h00, DIV_FRAC_O}, 16'h0000);
		rd(A_IER, 8'h00);
		rd(A_MCR, 8'h00);
		rd(A_SPR, 8'hFF);
		@(posedge CLK_I);
		IRQ_REQ_I <= 1'h1;
		TX_LINE_I <= 2'h2;
		RX_LINE_I <= 2'h1;
		RX_CNT_I  <= 8'h05;
		TX_CNT_I  <= 8'h09;
		repeat (2) @(posedge CLK_I);
		@(negedge CLK_I);
		chk({8'h00, IRQ_O, AUX_TX_O, TX485_O, RX485_O, 2'h0}, 16'h0064);
		for (int i = 0; i < 4; i++)
			wr(A_RES1 + 5'(i), 8'h11 + 8'(i));
		for (int i = 0; i < 4; i++)
			rd(A_RES1 + 5'(i), 8'h11 + 8'(i));
		wr(A_FCTL, 8'h80);
		wr(A_TRG, 8'h22);
		rd(A_TRG, 8'h09);
		wr(A_FCTL, 8'h00);
		wr(A_TRG, 8'h33);
		rd(A_TRG, 8'h05);
		chk({TRG_TX_O, TRG_RX_O}, 16'h2233);
		for (int m = 0; m < 4; m++)
			for (int k = 0; k < 2; k++)
			begin
				c1 = k[0] ? 8'h13 : 8'h11;
				c2 = k[0] ? 8'h14 : 8'h12;
				wr(A_EFEAT, 8'h10);
				wr(A_EFEAT, {4'h1, 2'(m), 2'h0});
				u_rem.got.delete();
				stall     <= (m == 3) ? 4'h2 : 4'h0;
				TX_REQ_I  <= 1'h1;
				TX_KIND_I <= k[0];
				@(posedge CLK_I);
				TX_REQ_I  <= 1'h0;
				repeat (12) @(posedge CLK_I);
				chk(16'(u_rem.got.size()), (m == 3) ? 16'h0002 : {15'h0000, m != 0});
				if (m != 0)
					chk({u_rem.got[0], u_rem.got[$]}, {m[1] ? c1 : c2, m[0] ? c2 : c1});
			end
		foreach (rxt[i])
		begin
			wr(A_EFEAT, 8'h10);
			wr(A_EFEAT, rxt[i][25:18]);
			p0 = npau;
			r0 = nres;
			u_rem.send(rxt[i][17:10]);
			u_rem.send(rxt[i][9:2]);
			repeat (3) @(posedge CLK_I);
			chk({8'(npau - p0), 8'(nres - r0)}, {7'h00, rxt[i][1], 7'h00, rxt[i][0]});
		end
		report_and_stop();
	end

	initial
	begin
		repeat (20000) @(posedge CLK_I);
		failures++;
		report_and_stop();
	end
endmodule

bind flow_cfg flow_cfg_properties u_prop (.CLK_I, .RSTN_I, .PORN_I, .ADDR_I, .WR_I, .RD_I,
	.RDATA_O, .RX_VLD_I, .RX_PAUSE_O, .RX_RESUME_O, .TX_REQ_I, .TX_TAKEN_I, .TX_CHAR_O,
	.TX_VLD_O, .TRG_RX_O, .DIV_O, .DIV_FRAC_O, .IRQ_OE16_N_O, .IRQ_OE68_N_O, .AUX_TX_O);
